// ==== common/pwg_pkg.sv ====
package pwg_pkg;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int LANE_W = 8;
    localparam int IDX_W = 3;
    localparam int WORD_LSB = 2;
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_CLEAR = 12'h000;
    localparam logic [11:0] OFS_SET = 12'h004;
    // protect bit positions, first group
    localparam int BIT_PWR_MGR = 1;
    localparam int BIT_OSC_CTRL = 2;
    localparam int BIT_CLK_GEN = 3;
    localparam int BIT_WATCHDOG = 4;
    localparam int BIT_RT_COUNTER = 5;
    localparam int BIT_EXT_IRQ = 6;
    localparam logic [31:0] IMPL_MASK = 32'h0000007E;
    localparam logic [31:0] PROT_RESET = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {SEL_CLEAR, SEL_SET, SEL_NONE} pwg_sel_t;
endpackage

// ==== common/pwg_guard_if.sv ====
`timescale 1ns/10ps
interface pwg_guard_if;
    logic reqValid;
    logic [pwg_pkg::IDX_W-1:0] reqIdx;
    logic [pwg_pkg::DATA_W-1:0] reqData;
    logic [pwg_pkg::DATA_W-1:0] protVec;
    logic fwdValid;
    logic [pwg_pkg::IDX_W-1:0] fwdIdx;
    logic [pwg_pkg::DATA_W-1:0] fwdData;
    logic errValid;
    logic [pwg_pkg::IDX_W-1:0] errIdx;
    modport filter (input reqValid, reqIdx, reqData, protVec,
        output fwdValid, fwdIdx, fwdData, errValid, errIdx);
    modport owner (output reqValid, reqIdx, reqData, protVec,
        input fwdValid, fwdIdx, fwdData, errValid, errIdx);
endinterface

// ==== logic/pwg_access_filter.sv ====
`timescale 1ns/10ps
module pwg_access_filter (
    input wire logic clk,
    input wire logic sys_rst,
    pwg_guard_if.filter g
);
    logic fwdValid_q, fwdValid_d;
    logic errValid_q, errValid_d;
    logic [pwg_pkg::IDX_W-1:0] fwdIdx_q, fwdIdx_d, errIdx_q, errIdx_d;
    logic [pwg_pkg::DATA_W-1:0] fwdData_q, fwdData_d;
    logic blocked;

    always_comb begin
        blocked = g.protVec[g.reqIdx];
        fwdValid_d = g.reqValid && !blocked;
        errValid_d = g.reqValid && blocked; // RULE_06
        fwdIdx_d = fwdIdx_q;
        fwdData_d = fwdData_q;
        errIdx_d = errIdx_q;
        if (fwdValid_d) begin
            fwdIdx_d = g.reqIdx;
            fwdData_d = g.reqData;
        end
        if (errValid_d) begin
            errIdx_d = g.reqIdx; // RULE_06
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fwdValid_q <= 1'b0;
            errValid_q <= 1'b0;
            fwdIdx_q <= '0;
            errIdx_q <= '0;
            fwdData_q <= '0;
        end else begin
            fwdValid_q <= fwdValid_d;
            errValid_q <= errValid_d;
            fwdIdx_q <= fwdIdx_d;
            errIdx_q <= errIdx_d;
            fwdData_q <= fwdData_d;
        end
    end

    assign g.fwdValid = fwdValid_q;
    assign g.fwdIdx = fwdIdx_q;
    assign g.fwdData = fwdData_q;
    assign g.errValid = errValid_q;
    assign g.errIdx = errIdx_q;

    property blockedWrite;
        @(posedge clk) disable iff (sys_rst)
        g.reqValid && g.protVec[g.reqIdx] |=> errValid_q && !fwdValid_q
            && errIdx_q == $past(g.reqIdx);
    endproperty
    blocked_write_a: assert property (blockedWrite) // RULE_06
        else $error("write to protected peripheral not refused");
    open_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
        g.reqValid && !g.protVec[g.reqIdx] |=> fwdValid_q && !errValid_q
            && fwdData_q == $past(g.reqData))
        else $error("write to open peripheral not forwarded");
    blocked_write_c: cover property (@(posedge clk) disable iff (sys_rst) errValid_q);
endmodule // pwg_access_filter

// ==== logic/pwg_top.sv ====
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
// Summary of operation
// (RULE_01) Protect bits are reached at two addresses, one only clears and one only sets.
// (RULE_02) A one written to the clear register drops that protect bit and opens the peripheral.
// (RULE_03) A one written to the set register raises that protect bit and guards the peripheral.
// (RULE_04) Both registers read back the same protect vector, one meaning protected.
// (RULE_05) A zero written through either register leaves the bit as it was.
// (RULE_06) A write to a protected peripheral is dropped and answered with an access error.
// (RULE_07) Setting a bit that is already set answers the register write with an error.
// (RULE_08) Clearing a bit that is already clear answers the register write with an error.
// (RULE_09) Byte, halfword and word accesses all work through the write strobes.
// (RULE_10) Bits 6 to 1 guard irq unit, rt counter, watchdog, clock gen, osc ctrl, power mgr.
// (RULE_11) Every implemented protect bit is zero after reset.
// (RULE_12) Software changing protection from several contexts must serialise or read first.
// (RULE_13) The set register sits at offset 0x04 and the clear register at 0x00.
// (RULE_14) Bit 0 and bits 31 to 7 read zero, ignore writes and never raise an error.
module pwg_top #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pwg_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [pwg_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pwg_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic perReqValid,
    input wire logic [pwg_pkg::IDX_W-1:0] perReqIdx,
    input wire logic [pwg_pkg::DATA_W-1:0] perReqData,
    output logic perFwdValid,
    output logic [pwg_pkg::IDX_W-1:0] perFwdIdx,
    output logic [pwg_pkg::DATA_W-1:0] perFwdData,
    output logic perErrValid,
    output logic [pwg_pkg::IDX_W-1:0] perErrIdx,
    output logic [pwg_pkg::DATA_W-1:0] protState
);
    function automatic pwg_pkg::pwg_sel_t decodeSel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = a & ~ADDR_W'({pwg_pkg::WORD_LSB{1'b1}});
        if (w == ADDR_W'(pwg_pkg::OFS_CLEAR)) begin // RULE_01 RULE_13
            return pwg_pkg::SEL_CLEAR;
        end else if (w == ADDR_W'(pwg_pkg::OFS_SET)) begin // RULE_13
            return pwg_pkg::SEL_SET;
        end
        return pwg_pkg::SEL_NONE;
    endfunction

    function automatic logic [pwg_pkg::DATA_W-1:0] laneMask(
        input logic [pwg_pkg::STRB_W-1:0] s);
        logic [pwg_pkg::DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < pwg_pkg::STRB_W; i++) begin
            m[i*pwg_pkg::LANE_W +: pwg_pkg::LANE_W] = {pwg_pkg::LANE_W{s[i]}}; // RULE_09
        end
        return m;
    endfunction

    // write channel state
    logic awPend_q, awPend_d, wPend_q, wPend_d;
    logic awReady_q, awReady_d, wReady_q, wReady_d;
    logic [ADDR_W-1:0] awAddr_q, awAddr_d;
    logic [pwg_pkg::DATA_W-1:0] wData_q, wData_d;
    logic [pwg_pkg::STRB_W-1:0] wStrb_q, wStrb_d;
    logic bValid_q, bValid_d;
    logic [1:0] bResp_q, bResp_d;
    logic [pwg_pkg::DATA_W-1:0] prot_q, prot_d;
    logic doWr;
    pwg_pkg::pwg_sel_t wrSel;
    logic [pwg_pkg::DATA_W-1:0] hits;

    always_comb begin
        doWr = awPend_q && wPend_q && !bValid_q;
        wrSel = decodeSel(awAddr_q);
        hits = wData_q & laneMask(wStrb_q) & pwg_pkg::IMPL_MASK; // RULE_09 RULE_14
        awPend_d = awPend_q;
        wPend_d = wPend_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        prot_d = prot_q;
        if (s_axi_awvalid && awReady_q) begin
            awPend_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_q) begin
            wPend_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
        if (doWr) begin
            awPend_d = 1'b0;
            wPend_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = pwg_pkg::RESP_OKAY;
            unique case (wrSel)
                pwg_pkg::SEL_CLEAR: begin
                    prot_d = prot_q & ~hits; // RULE_02 RULE_05
                    if (|(hits & ~prot_q)) begin
                        bResp_d = pwg_pkg::RESP_SLVERR; // RULE_08
                    end
                end
                pwg_pkg::SEL_SET: begin
                    prot_d = prot_q | hits; // RULE_03 RULE_05
                    if (|(hits & prot_q)) begin
                        bResp_d = pwg_pkg::RESP_SLVERR; // RULE_07
                    end
                end
                pwg_pkg::SEL_NONE: begin
                    bResp_d = pwg_pkg::RESP_DECERR;
                end
            endcase
        end
        awReady_d = !awPend_d;
        wReady_d = !wPend_d;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awPend_q <= 1'b0;
            wPend_q <= 1'b0;
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bValid_q <= 1'b0;
            bResp_q <= pwg_pkg::RESP_OKAY;
            prot_q <= pwg_pkg::PROT_RESET; // RULE_11
        end else begin
            awPend_q <= awPend_d;
            wPend_q <= wPend_d;
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            prot_q <= prot_d;
        end
    end

    // read channel state
    logic arReady_q, arReady_d, rValid_q, rValid_d;
    logic [pwg_pkg::DATA_W-1:0] rData_q, rData_d;
    logic [1:0] rResp_q, rResp_d;
    logic arFire;

    always_comb begin
        arFire = s_axi_arvalid && arReady_q;
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
        if (arFire) begin
            rValid_d = 1'b1;
            if (decodeSel(s_axi_araddr) == pwg_pkg::SEL_NONE) begin
                rData_d = '0;
                rResp_d = pwg_pkg::RESP_DECERR;
            end else begin
                rData_d = prot_q & pwg_pkg::IMPL_MASK; // RULE_04 RULE_14
                rResp_d = pwg_pkg::RESP_OKAY;
            end
        end
        arReady_d = !rValid_d;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
            rData_q <= '0;
            rResp_q <= pwg_pkg::RESP_OKAY;
        end else begin
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

    // peripheral write guard
    pwg_guard_if guardBus ();
    assign guardBus.reqValid = perReqValid;
    assign guardBus.reqIdx = perReqIdx;
    assign guardBus.reqData = perReqData;
    assign guardBus.protVec = prot_q; // RULE_06 RULE_10

    pwg_access_filter accessFilter (
        .clk(clk),
        .sys_rst(sys_rst),
        .g(guardBus.filter)
    );

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign perFwdValid = guardBus.fwdValid;
    assign perFwdIdx = guardBus.fwdIdx;
    assign perFwdData = guardBus.fwdData;
    assign perErrValid = guardBus.errValid;
    assign perErrIdx = guardBus.errIdx;
    assign protState = prot_q;

    // peripherals guarded in the first group
    localparam logic [pwg_pkg::DATA_W-1:0] GUARD_BITS =
        (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_EXT_IRQ)
        | (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_RT_COUNTER)
        | (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_WATCHDOG)
        | (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_CLK_GEN)
        | (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_OSC_CTRL)
        | (pwg_pkg::DATA_W'(1'b1) << pwg_pkg::BIT_PWR_MGR);

    // checks
    logic firstCyc_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            firstCyc_q <= 1'b1;
        end else begin
            firstCyc_q <= 1'b0;
        end
    end

    reset_value_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
        firstCyc_q |-> prot_q == pwg_pkg::PROT_RESET)
        else $error("protect bits not zero after reset");
    unimpl_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
        (prot_q & ~pwg_pkg::IMPL_MASK) == '0 && (!rValid_q || rResp_q != pwg_pkg::RESP_OKAY
            || (rData_q & ~pwg_pkg::IMPL_MASK) == '0))
        else $error("unimplemented protect bit seen as one");
    set_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
        doWr && wrSel == pwg_pkg::SEL_SET |=> (prot_q & $past(hits)) == $past(hits))
        else $error("set register write did not raise bits");
    clear_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
        doWr && wrSel == pwg_pkg::SEL_CLEAR |=> (prot_q & $past(hits)) == '0)
        else $error("clear register write did not drop bits");
    zero_keeps_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
        doWr |=> (prot_q & ~$past(hits)) == ($past(prot_q) & ~$past(hits)))
        else $error("bit written with zero changed");
    byte_lane_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
        doWr && !wStrb_q[0] |=> prot_q[pwg_pkg::LANE_W-1:0]
            == $past(prot_q[pwg_pkg::LANE_W-1:0]))
        else $error("unstrobed byte lane changed");
    double_set_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
        doWr && wrSel == pwg_pkg::SEL_SET && |(hits & prot_q)
            |=> s_axi_bvalid && s_axi_bresp == pwg_pkg::RESP_SLVERR)
        else $error("double protect not answered with error");
    double_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
        doWr && wrSel == pwg_pkg::SEL_CLEAR && |(hits & ~prot_q)
            |=> s_axi_bvalid && s_axi_bresp == pwg_pkg::RESP_SLVERR)
        else $error("double unprotect not answered with error");
    read_same_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
        arFire && decodeSel(s_axi_araddr) != pwg_pkg::SEL_NONE
            |=> s_axi_rvalid && s_axi_rdata == $past(prot_q))
        else $error("read of protect register differs from state");
    guard_map_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
        perReqValid && prot_q[perReqIdx] |=> perErrValid && GUARD_BITS[perErrIdx])
        else $error("refused write outside guarded bits");
    read_err_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
        arFire && decodeSel(s_axi_araddr) == pwg_pkg::SEL_NONE
            |=> s_axi_rvalid && s_axi_rresp == pwg_pkg::RESP_DECERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    decode_err_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
        doWr && wrSel == pwg_pkg::SEL_NONE
            |=> s_axi_bresp == pwg_pkg::RESP_DECERR && prot_q == $past(prot_q))
        else $error("unmapped write not refused");
    ready_after_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
        doWr |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write channels not reopened after write");

    set_then_clear_c: cover property (@(posedge clk) disable iff (sys_rst)
        doWr && wrSel == pwg_pkg::SEL_SET ##[1:20] doWr && wrSel == pwg_pkg::SEL_CLEAR);
    double_set_c: cover property (@(posedge clk) disable iff (sys_rst)
        s_axi_bvalid && s_axi_bresp == pwg_pkg::RESP_SLVERR);
    read_back_c: cover property (@(posedge clk) disable iff (sys_rst)
        s_axi_rvalid && s_axi_rdata != '0);
    decode_err_c: cover property (@(posedge clk) disable iff (sys_rst)
        s_axi_bvalid && s_axi_bresp == pwg_pkg::RESP_DECERR);
endmodule // pwg_top

// ==== test/pwg_core_model.sv ====
`timescale 1ns/10ps
module pwg_core_model (
    input wire logic clk,
    output logic perReqValid,
    output logic [pwg_pkg::IDX_W-1:0] perReqIdx,
    output logic [pwg_pkg::DATA_W-1:0] perReqData,
    input wire logic perFwdValid,
    input wire logic perErrValid
);
    initial begin
        perReqValid = 1'b0;
        perReqIdx = 3'h0;
        perReqData = 32'h0;
    end
    // one write pulse, outcome sampled in the cycle after it is taken
    task automatic poke(input logic [pwg_pkg::IDX_W-1:0] i, input logic [31:0] d,
            output logic fwd, output logic err);
        @(posedge clk);
        perReqValid <= 1'b1;
        perReqIdx <= i;
        perReqData <= d;
        @(posedge clk);
        perReqValid <= 1'b0;
        perReqIdx <= ~i;
        perReqData <= ~d;
        @(posedge clk);
        fwd = perFwdValid;
        err = perErrValid;
    endtask
endmodule // pwg_core_model

// ==== test/test_peripheral_write_protect_guard.sv ====
`timescale 1ns/10ps
module test_peripheral_write_protect_guard;
    localparam logic [1:0] OK = pwg_pkg::RESP_OKAY;
    localparam logic [1:0] SE = pwg_pkg::RESP_SLVERR;
    localparam logic [1:0] DE = pwg_pkg::RESP_DECERR;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [1:0] r;
        logic [31:0] v;
    } pwg_row_t;
    pwg_row_t rows[15] = '{
        '{12'h004, 32'h0000007E, 4'hF, OK, 32'h0000007E},
        '{12'h004, 32'h00000002, 4'hF, SE, 32'h0000007E},
        '{12'h000, 32'h00000010, 4'hF, OK, 32'h0000006E},
        '{12'h000, 32'h00000010, 4'hF, SE, 32'h0000006E},
        '{12'h004, 32'h00000000, 4'hF, OK, 32'h0000006E},
        '{12'h000, 32'h00000000, 4'hF, OK, 32'h0000006E},
        '{12'h004, 32'hFFFFFF81, 4'hF, OK, 32'h0000006E},
        '{12'h004, 32'h00000010, 4'h0, OK, 32'h0000006E},
        '{12'h004, 32'h00000010, 4'h1, OK, 32'h0000007E},
        '{12'h000, 32'h00007E00, 4'h2, OK, 32'h0000007E},
        '{12'h000, 32'h0000007E, 4'h1, OK, 32'h00000000},
        '{12'h008, 32'h0000007E, 4'hF, DE, 32'h00000000},
        '{12'h004, 32'h00000006, 4'hF, OK, 32'h00000006},
        '{12'h004, 32'h0000000E, 4'hF, SE, 32'h0000000E},
        '{12'h000, 32'h00000002, 4'h3, OK, 32'h0000000C}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic perReqValid;
    logic [2:0] perReqIdx;
    logic [31:0] perReqData;
    logic perFwdValid;
    logic [2:0] perFwdIdx;
    logic [31:0] perFwdData;
    logic perErrValid;
    logic [2:0] perErrIdx;
    logic [31:0] protState;
    int err_total = 0;
    int checks = 0;
    always #2 clk = ~clk;
    pwg_top DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .perReqValid(perReqValid), .perReqIdx(perReqIdx),
        .perReqData(perReqData), .perFwdValid(perFwdValid), .perFwdIdx(perFwdIdx),
        .perFwdData(perFwdData), .perErrValid(perErrValid), .perErrIdx(perErrIdx),
        .protState(protState));
    pwg_core_model CORE (.clk(clk), .perReqValid(perReqValid), .perReqIdx(perReqIdx),
        .perReqData(perReqData), .perFwdValid(perFwdValid), .perErrValid(perErrValid));
    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_vec({30'h0, got}, {30'h0, exp});
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_vec({31'h0, got}, {31'h0, exp});
    endtask
    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input int late, output logic [1:0] r);
        int n;
        logic bDone;
        n = 0;
        bDone = 1'b0;
        r = 2'h1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= (late == 0);
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bDone && n < 200) begin
            @(posedge clk);
            n++;
            if (n == late) s_axi_awvalid <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                bDone = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
        if (!bDone) err_total++;
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic rDone;
        n = 0;
        rDone = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rDone && n < 200) begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                rDone = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
        if (!rDone) err_total++;
    endtask
    task automatic check_state(input logic [31:0] v);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(pwg_pkg::OFS_CLEAR, d, r);
        cmp_vec(d, v);
        axi_read(pwg_pkg::OFS_SET, d, r);
        cmp_vec(d, v);
        cmp_resp(r, OK);
        cmp_vec(protState, v);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [31:0] lastFwd;
        logic f;
        logic e;
        lastFwd = 32'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        check_state(pwg_pkg::PROT_RESET);
        axi_read(12'h008, d, r);
        cmp_resp(r, DE);
        foreach (rows[k]) begin
            axi_write(rows[k].a, rows[k].d, rows[k].s, 0, r);
            cmp_resp(r, rows[k].r);
            check_state(rows[k].v);
        end
        // every index against the last protect vector, 0C
        for (int i = 0; i < 8; i++) begin
            CORE.poke(i[2:0], 32'hC3A50000 + i, f, e);
            cmp_bit(e, rows[14].v[i]);
            cmp_bit(f, !rows[14].v[i]);
            if (rows[14].v[i]) begin
                cmp_vec({29'h0, perErrIdx}, i);
                cmp_vec(perFwdData, lastFwd);
            end else begin
                lastFwd = 32'hC3A50000 + i;
                cmp_vec(perFwdData, lastFwd);
                cmp_vec({29'h0, perFwdIdx}, i);
            end
        end
        // address arrives three cycles after the data
        axi_write(pwg_pkg::OFS_CLEAR, 32'h0000000C, 4'hF, 3, r);
        cmp_resp(r, OK);
        CORE.poke(3'h3, 32'h5A5A0003, f, e);
        cmp_bit(f, 1'b1);
        // second reset in mid-run
        axi_write(pwg_pkg::OFS_SET, 32'h0000007E, 4'hF, 0, r);
        cmp_resp(r, OK);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        check_state(32'h0);
        stop_test();
    end
endmodule // test_peripheral_write_protect_guard
